// File: hdl/vlsu_top.sv
// How it works
// R1: Unit-stride moves 8, 16, 32, 64-bit elements.
// R2: Masked mode uses mask register zero bits.
// R3: Mask ops: unmasked bytes, length ceil(len/8).
// R4: Mask loads always write tail-agnostic.
// R5: Mask ops share width zero, differ by variant.
// R6: Mask op resume index counts bytes.
// R7: Illegal-configuration flag rejects mask ops too.
// R8: Strides may be negative, zero or positive.
// R9: Strided element accesses carry no ordering.
// R10: Zero-register stride may skip memory accesses.
// R11: Zero-valued stride register: access every element.
// R12: Never elide accesses to non-idempotent memory.
// R13: Indexed forms, 8-64 bit offsets, data width.
// R14: First-fault load traps only on element zero.
// R15: Element zero fault keeps length, takes trap.
// R16: Later fault trims length, suppresses trap.
// R17: No writeback at or past trimmed length.
// R18: Non-idempotent load only when not restartable.
// R19: Variant 01011 with byte width selects mask.
// R20: Unit-stride walks contiguously from base.
// R21: Strided address is base plus index*stride.
// R22: Offsets zero-extended or truncated to width.
`timescale 1ns/1ps
module vlsu_top
   import vlsu_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [vlsu_pkg::WB_AW-1:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatI,
   output logic [31:0] wbDatO,
   output logic wbAck,
   output logic [vlsu_pkg::VL_W-1:0] elemIdx,
   input wire logic elemMaskBit,
   input wire logic [vlsu_pkg::ADDR_W-1:0] elemData,
   input wire logic [vlsu_pkg::ADDR_W-1:0] elemIndex,
   output logic memReq,
   output logic memWe,
   output logic [vlsu_pkg::ADDR_W-1:0] memAddr,
   output logic [1:0] memSize,
   output logic [vlsu_pkg::ADDR_W-1:0] memWdata,
   input wire logic memAck,
   input wire logic [vlsu_pkg::ADDR_W-1:0] memRdata,
   input wire logic memFault,
   input wire logic memNonIdem,
   output logic resValid,
   output logic [vlsu_pkg::VL_W-1:0] resIdx,
   output logic [vlsu_pkg::ADDR_W-1:0] resData,
   output logic resTailAgnostic
);
   import vlsu_pkg::*;

   // ==========================================================
   // Helper functions.
   // ==========================================================
   // Log2 of the byte size for a width code; illegal codes give 0.
   function automatic logic [1:0] widthLg(input logic [2:0] code);
      logic [1:0] r;
      r = 2'h0;
      if (code == W16) r = 2'h1;
      else if (code == W32) r = 2'h2;
      else if (code == W64) r = 2'h3;
      return r;
   endfunction

   // True for the four width codes that name vector elements.
   function automatic logic widthOk(input logic [2:0] code);
      return (code == W8) || (code == W16) || (code == W32) || (code == W64);
   endfunction

   // Byte-lane merge of a Wishbone write into a stored word.
   function automatic logic [31:0] selMerge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
      return r;
   endfunction

   // ==========================================================
   // State.
   // ==========================================================
   vlsu_state_e state; // Sequencer state.
   logic [CMD_W-1:0] cmd; // Instruction fields written by software.
   logic [VL_W-1:0] lenReg; // Active vector length.
   logic [VL_W-1:0] startReg; // Resume index.
   logic [ADDR_W-1:0] baseReg; // Scalar base address.
   logic [ADDR_W-1:0] strideReg; // Signed byte stride.
   logic busy; // A transfer is running.
   logic doneFlag; // Last run finished.
   logic trapFlag; // Last run ended in a trap.
   logic illegalFlag; // Last start was refused.
   logic trimFlag; // Last run trimmed the length.
   logic cacheOk; // The cached element is reusable.
   logic [ADDR_W-1:0] cacheData; // Element kept for zero-register strides.
   logic [31:0] rdData; // Read mux output.

   // ==========================================================
   // Command decoding.
   // ==========================================================
   wire isStore = cmd[CMD_STORE];
   wire [1:0] mop = cmd[CMD_MOP +: 2];
   wire [4:0] unitVar = cmd[CMD_VAR +: 5];
   wire [2:0] widthCode = cmd[CMD_WIDTH +: 3];
   wire maskSelectBit = cmd[CMD_MASK];
   wire strideIsZeroReg = cmd[CMD_ZREG];
   wire [1:0] selectedElementWidth = cmd[CMD_SEW +: 2];
   wire tailAgnosticCfg = cmd[CMD_TAIL];
   wire vill = cmd[CMD_VILL];
   wire isUnit = (mop == MOP_UNIT);
   wire isStrided = (mop == MOP_STRIDED);
   // Bit zero of the mode field marks both indexed forms.
   wire isIndexed = mop[0];
   // Width zero is shared with byte loads; only the variant differs.
   wire maskOp = isUnit && unitVar == VAR_MASK && widthCode == W8; // R5 R19
   wire ffOp = !isStore && isUnit && unitVar == VAR_FFIRST; // R14
   wire varOk = unitVar == VAR_PLAIN || maskOp || ffOp;
   // Whole-register and other variants are refused as illegal.
   wire cmdLegal = !vill && widthOk(widthCode) && (!isUnit || varOk); // R7
   // Mask ops move ceil(len/8) bytes.
   wire [VL_W-1:0] evl = maskOp ? ({3'h0, lenReg[VL_W-1:3]} + {15'h0000, |lenReg[2:0]})
                                : lenReg; // R3
   // Indexed forms take data width from the configuration.
   wire [1:0] dataLg = isIndexed ? selectedElementWidth : widthLg(widthCode); // R1 R13
   wire [1:0] idxLg = widthLg(widthCode); // R13
   // Offsets keep only the bits of the encoded index width.
   wire [ADDR_W-1:0] idxMask = {{32{idxLg == 2'h3}}, {16{idxLg[1]}},
                                {8{idxLg != 2'h0}}, 8'hFF}; // R22
   // Mask ops are never masked.
   wire activeElem = maskOp || !maskSelectBit || elemMaskBit; // R2 R3
   wire [ADDR_W-1:0] idxWide = {48'h0000_0000_0000, elemIdx};
   // Modular product handles negative and zero strides alike.
   wire [ADDR_W-1:0] strideOff = strideReg * idxWide; // R8 R21
   wire [ADDR_W-1:0] unitOff = idxWide << dataLg; // R20
   wire [ADDR_W-1:0] offset = isIndexed ? (elemIndex & idxMask)
                            : isStrided ? strideOff : unitOff; // R22
   wire [ADDR_W-1:0] nextAddr = baseReg + offset;
   // Only the zero register stride lets a load reuse a fetched value.
   wire reuse = !isStore && isStrided && strideIsZeroReg && cacheOk; // R10 R12
   wire inRange = elemIdx < evl;
   wire issue = state == ST_ELEM && inRange && activeElem && !reuse;
   // Mask loads override the configured tail policy.
   wire tailAgn = maskOp || tailAgnosticCfg; // R4

   // ==========================================================
   // Wishbone slave.
   // ==========================================================
   wire wbHit = wbCyc && wbStb && !wbAck;
   wire wrEn = wbHit && wbWe;
   // Configuration writes are ignored while a transfer runs.
   wire cfgWr = wrEn && !busy;
   wire go = cfgWr && wbAdr == REG_CTRL && wbSel[0] && wbDatI[CTRL_GO];
   wire lenWr = cfgWr && wbAdr == REG_LEN;
   wire startWr = cfgWr && wbAdr == REG_START;
   wire [31:0] lenMerge = selMerge({16'h0000, lenReg}, wbDatI, wbSel);
   wire [31:0] startMerge = selMerge({16'h0000, startReg}, wbDatI, wbSel);
   wire [31:0] cmdMerge = selMerge({15'h0000, cmd}, wbDatI, wbSel);

   // Read mux; unmapped offsets read as zero and still acknowledge.
   always_comb
   begin
      rdData = 32'h0000_0000;
      if (wbAdr == REG_CTRL)
      begin
         rdData[STAT_BUSY] = busy;
         rdData[STAT_DONE] = doneFlag;
         rdData[STAT_TRAP] = trapFlag;
         rdData[STAT_ILLEGAL] = illegalFlag;
         rdData[STAT_TRIM] = trimFlag;
      end
      else if (wbAdr == REG_CMD) rdData = {15'h0000, cmd};
      else if (wbAdr == REG_LEN) rdData = {16'h0000, lenReg};
      else if (wbAdr == REG_START) rdData = {16'h0000, startReg};
      else if (wbAdr == REG_BASE_LO) rdData = baseReg[31:0];
      else if (wbAdr == REG_BASE_HI) rdData = baseReg[63:32];
      else if (wbAdr == REG_STRIDE_LO) rdData = strideReg[31:0];
      else if (wbAdr == REG_STRIDE_HI) rdData = strideReg[63:32];
   end

   // Bus answer and the plain configuration words; ack lasts one cycle.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         wbAck <= 1'b0;
         wbDatO <= 32'h0000_0000;
         cmd <= CMD_RST;
         baseReg <= ADDR_RST;
         strideReg <= ADDR_RST;
      end
      else
      begin
         wbAck <= wbHit;
         wbDatO <= rdData;
         if (cfgWr && wbAdr == REG_CMD) cmd <= cmdMerge[CMD_W-1:0];
         if (cfgWr && wbAdr == REG_BASE_LO) baseReg[31:0] <= selMerge(baseReg[31:0], wbDatI, wbSel);
         if (cfgWr && wbAdr == REG_BASE_HI) baseReg[63:32] <= selMerge(baseReg[63:32], wbDatI, wbSel);
         if (cfgWr && wbAdr == REG_STRIDE_LO) strideReg[31:0] <= selMerge(strideReg[31:0], wbDatI, wbSel);
         if (cfgWr && wbAdr == REG_STRIDE_HI) strideReg[63:32] <= selMerge(strideReg[63:32], wbDatI, wbSel);
      end
   end

   // ==========================================================
   // Element sequencer.
   // ==========================================================
   // Elements go one at a time in index order, which satisfies both the
   // ordered and unordered forms; a fault is always known before the next
   // element is touched, so nothing is ever accessed speculatively.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state <= ST_IDLE;
         busy <= 1'b0;
         doneFlag <= 1'b0;
         trapFlag <= 1'b0;
         illegalFlag <= 1'b0;
         trimFlag <= 1'b0;
         lenReg <= LEN_RST;
         startReg <= LEN_RST;
         elemIdx <= LEN_RST;
         memReq <= 1'b0;
         memWe <= 1'b0;
         memAddr <= ADDR_RST;
         memSize <= 2'h0;
         memWdata <= ADDR_RST;
         resValid <= 1'b0;
         resIdx <= LEN_RST;
         resData <= ADDR_RST;
         resTailAgnostic <= 1'b0;
         cacheOk <= 1'b0;
         cacheData <= ADDR_RST;
      end
      else
      begin
         resValid <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (lenWr) lenReg <= lenMerge[VL_W-1:0];
               if (startWr) startReg <= startMerge[VL_W-1:0];
               if (go)
               begin
                  doneFlag <= 1'b0;
                  trapFlag <= 1'b0;
                  illegalFlag <= 1'b0;
                  trimFlag <= 1'b0;
                  cacheOk <= 1'b0;
                  if (!cmdLegal) illegalFlag <= 1'b1; // R7
                  else if (startReg >= evl)
                  begin
                     doneFlag <= 1'b1;
                     startReg <= LEN_RST;
                  end
                  else
                  begin
                     busy <= 1'b1;
                     elemIdx <= startReg;
                     state <= ST_ELEM;
                  end
               end
            end
            ST_ELEM:
            begin
               if (!inRange)
               begin
                  // All elements done; the resume index returns to zero.
                  busy <= 1'b0;
                  doneFlag <= 1'b1;
                  startReg <= LEN_RST;
                  state <= ST_IDLE;
               end
               else if (!activeElem) elemIdx <= elemIdx + IDX_ONE; // R2
               else if (reuse)
               begin
                  // Saves a bus cycle; only idempotent data is ever reused.
                  resValid <= 1'b1; // R10
                  resIdx <= elemIdx;
                  resData <= cacheData;
                  resTailAgnostic <= tailAgn;
                  elemIdx <= elemIdx + IDX_ONE;
               end
               else
               begin
                  // A register stride of value zero still hits every element.
                  memReq <= 1'b1; // R11 R9
                  memWe <= isStore;
                  memAddr <= nextAddr; // R20 R21 R13
                  memSize <= dataLg; // R1
                  memWdata <= elemData;
                  state <= ST_REQ;
               end
            end
            ST_REQ:
            begin
               if (memAck)
               begin
                  memReq <= 1'b0;
                  if (memFault && ffOp && elemIdx != LEN_RST)
                  begin
                     // Trim and finish; nothing is written back from here on.
                     lenReg <= elemIdx; // R16 R17
                     trimFlag <= 1'b1;
                     doneFlag <= 1'b1;
                     startReg <= LEN_RST;
                     busy <= 1'b0;
                     state <= ST_IDLE;
                  end
                  else if (memFault)
                  begin
                     // Length kept; the index counts bytes for mask ops.
                     trapFlag <= 1'b1; // R14 R15
                     startReg <= elemIdx; // R6
                     busy <= 1'b0;
                     state <= ST_IDLE;
                  end
                  else
                  begin
                     // The access has completed, so it will not be restarted.
                     resValid <= !isStore; // R18
                     resIdx <= elemIdx;
                     resData <= memRdata;
                     resTailAgnostic <= tailAgn; // R4
                     cacheOk <= !memNonIdem && isStrided && strideIsZeroReg; // R12
                     cacheData <= memRdata;
                     elemIdx <= elemIdx + IDX_ONE;
                     state <= ST_ELEM;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Assertions.
   // ==========================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Rounded-up byte count computed a second way.
   wire [VL_W:0] ceilLen = ({1'b0, lenReg} + LEN_ROUND) >> 3;

   sequence seqFfFault;
      state == ST_REQ && memAck && memFault && ffOp;
   endsequence

   sequence seqLastAck;
      state == ST_REQ && memAck && !memFault && elemIdx == evl - IDX_ONE;
   endsequence

   AST_MASK_TAIL: assert property (resValid && maskOp |-> resTailAgnostic) // R4
      else $error("mask load result not tail-agnostic");
   AST_MASK_LEN: assert property (busy && maskOp |-> {1'b0, evl} == ceilLen) // R3
      else $error("mask op length is not ceil(len/8)");
   AST_ILLEGAL: assert property (go && !cmdLegal |=> illegalFlag && !busy && !memReq) // R7
      else $error("illegal command was started");
   AST_UNIT_ADDR: assert property (issue && isUnit |=>
      memReq && memAddr == baseReg + (idxWide << dataLg)) // R20
      else $error("unit-stride address wrong");
   AST_STRIDE_ADDR: assert property (issue && isStrided |=>
      memAddr - baseReg == strideReg * idxWide) // R21
      else $error("strided address wrong");
   AST_INDEX_ADDR: assert property (issue && isIndexed |=>
      memAddr == baseReg + ($past(elemIndex) & idxMask)) // R22
      else $error("indexed address wrong");
   AST_MASK_GATE: assert property (state == ST_ELEM && inRange && !activeElem |=>
      !memReq && !resValid) // R2
      else $error("inactive element was accessed");
   AST_ZERO_VAL: assert property (state == ST_ELEM && inRange && activeElem && isStrided &&
      !strideIsZeroReg |=> memReq) // R11
      else $error("zero-valued stride skipped an access");
   AST_NONIDEM: assert property (state == ST_REQ && memAck && memNonIdem |=> !cacheOk) // R12
      else $error("non-idempotent data kept for reuse");
   AST_FF_TRAP: assert property (seqFfFault and elemIdx == LEN_RST |=>
      trapFlag && $stable(lenReg) && state == ST_IDLE) // R15
      else $error("element zero fault did not trap");
   AST_FF_TRIM: assert property (seqFfFault and elemIdx != LEN_RST |=>
      !trapFlag && trimFlag && lenReg == $past(elemIdx) && !resValid) // R16
      else $error("later fault did not trim");
   AST_REQ_HOLD: assert property (memReq && !memAck |=>
      memReq && $stable(memAddr) && $stable(memWdata)) // R18
      else $error("memory request changed before ack");
   AST_LAST_DONE: assert property (seqLastAck |=> state == ST_ELEM ##1 doneFlag && !busy) // R1
      else $error("run did not finish after last element");
endmodule // vlsu_top

// File: hdl/vlsu_pkg.sv
// ==========================================================
// Shared constants of the vector load/store unit.
// ==========================================================
package vlsu_pkg;
   // Scalar register width, which is also the address and data width.
   localparam int ADDR_W = 64;
   // Width of the active vector length and of element indices.
   localparam int VL_W = 16;
   // Width of the command register.
   localparam int CMD_W = 17;
   // Wishbone byte address width.
   localparam int WB_AW = 8;

   // ==========================================================
   // Register byte offsets.
   // ==========================================================
   localparam logic [WB_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [WB_AW-1:0] REG_CMD = 8'h04;
   localparam logic [WB_AW-1:0] REG_LEN = 8'h08;
   localparam logic [WB_AW-1:0] REG_START = 8'h0C;
   localparam logic [WB_AW-1:0] REG_BASE_LO = 8'h10;
   localparam logic [WB_AW-1:0] REG_BASE_HI = 8'h14;
   localparam logic [WB_AW-1:0] REG_STRIDE_LO = 8'h18;
   localparam logic [WB_AW-1:0] REG_STRIDE_HI = 8'h1C;

   // ==========================================================
   // Field positions.
   // ==========================================================
   localparam int CTRL_GO = 0;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_TRAP = 2;
   localparam int STAT_ILLEGAL = 3;
   localparam int STAT_TRIM = 4;
   localparam int CMD_STORE = 0;
   localparam int CMD_MOP = 1;
   localparam int CMD_VAR = 3;
   localparam int CMD_WIDTH = 8;
   localparam int CMD_MASK = 11;
   localparam int CMD_ZREG = 12;
   localparam int CMD_SEW = 13;
   localparam int CMD_TAIL = 15;
   localparam int CMD_VILL = 16;

   // ==========================================================
   // Encodings.
   // ==========================================================
   localparam logic [1:0] MOP_UNIT = 2'h0;
   localparam logic [1:0] MOP_STRIDED = 2'h2;
   localparam logic [4:0] VAR_PLAIN = 5'h00;
   localparam logic [4:0] VAR_MASK = 5'h0B;
   localparam logic [4:0] VAR_FFIRST = 5'h10;
   localparam logic [2:0] W8 = 3'h0;
   localparam logic [2:0] W16 = 3'h5;
   localparam logic [2:0] W32 = 3'h6;
   localparam logic [2:0] W64 = 3'h7;

   // ==========================================================
   // Reset values and counts.
   // ==========================================================
   localparam logic [CMD_W-1:0] CMD_RST = 17'h0_0000;
   localparam logic [VL_W-1:0] LEN_RST = 16'h0000;
   localparam logic [VL_W-1:0] IDX_ONE = 16'h0001;
   localparam logic [VL_W:0] LEN_ROUND = 17'h0_0007;
   localparam logic [ADDR_W-1:0] ADDR_RST = 64'h0000_0000_0000_0000;

   // Sequencer states.
   typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_ELEM = 3'h2, ST_REQ = 3'h4} vlsu_state_e;
endpackage

// File: bench/vlsu_mem_model.sv
`timescale 1ns/1ps
// ==========================================================
// Memory seen by the unit: answers each element request.
// ==========================================================
module vlsu_mem_model
   import vlsu_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic memReq,
   input wire logic [vlsu_pkg::ADDR_W-1:0] memAddr,
   input wire logic [3:0] lat,
   input wire logic faultOn,
   input wire logic [vlsu_pkg::ADDR_W-1:0] faultAddr,
   output logic memAck,
   output logic [vlsu_pkg::ADDR_W-1:0] memRdata,
   output logic memFault
);
   logic [3:0] waitCnt; // Cycles the pending request has waited.
   // Read data is the inverted address, so each element is traceable.
   // Between answers the data flips every cycle, so stale values never look valid.
   always_ff @(posedge clk)
   begin
      memAck <= 1'b0;
      memFault <= 1'b0;
      memRdata <= ~memRdata;
      if (!nrst)
      begin
         waitCnt <= 4'h0;
         memRdata <= 64'h0000_0000_0000_0000;
      end
      else if (memReq && !memAck)
      begin
         // A slow memory is made by raising lat; zero answers promptly.
         if (waitCnt >= lat)
         begin
            memAck <= 1'b1;
            memRdata <= ~memAddr;
            memFault <= faultOn && (memAddr == faultAddr);
            waitCnt <= 4'h0;
         end
         else
            waitCnt <= waitCnt + 4'h1;
      end
   end
endmodule // vlsu_mem_model

// File: bench/vlsu_top_tb_top.sv
`timescale 1ns/1ps
module vlsu_top_tb_top;
   import vlsu_pkg::*;
   // ==========================================================
   // Stimulus and observation signals.
   // ==========================================================
   localparam logic [63:0] B = 64'h0000_0000_0000_1000; // Base of every access.
   logic clk, nrst, wbCyc, wbStb, wbWe, wbAck, memReq, memWe, memAck, memFault;
   logic resValid, resTailAgnostic, faultOn, elemMaskBit, weSeen, taSeen, nonIdem;
   logic [7:0] wbAdr;
   logic [3:0] wbSel, lat;
   logic [31:0] wbDatI, wbDatO, stat;
   logic [15:0] elemIdx, resIdx, maskPat;
   logic [1:0] memSize;
   logic [63:0] elemData, elemIndex, memAddr, memWdata, memRdata, resData, faultAddr, lastRes;
   logic [63:0] aLog [16];
   int nFail = 0;
   int testsRun = 0;
   int nReq, nRes;
   // Core side: mask bit and store data follow the element index at once.
   assign elemMaskBit = maskPat[elemIdx[3:0]];
   assign elemData = {48'h0000_0000_0000, elemIdx};
   always #4 clk = ~clk;
   vlsu_top DUT (.clk(clk), .nrst(nrst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
      .elemIdx(elemIdx), .elemMaskBit(elemMaskBit), .elemData(elemData),
      .elemIndex(elemIndex), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
      .memSize(memSize), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
      .memFault(memFault), .memNonIdem(nonIdem), .resValid(resValid), .resIdx(resIdx),
      .resData(resData), .resTailAgnostic(resTailAgnostic));
   vlsu_mem_model MEM (.clk(clk), .nrst(nrst), .memReq(memReq), .memAddr(memAddr),
      .lat(lat), .faultOn(faultOn), .faultAddr(faultAddr), .memAck(memAck),
      .memRdata(memRdata), .memFault(memFault));
   // Log every accepted element access in order; count load results and keep the last one.
   always @(posedge clk)
   begin
      if (memReq && memAck)
      begin
         aLog[nReq[3:0]] = memAddr;
         weSeen = memWe;
         nReq++;
      end
      if (resValid)
      begin
         nRes++;
         taSeen = resTailAgnostic;
         lastRes = resData;
      end
   end
   // ==========================================================
   // Shared tasks.
   // ==========================================================
   task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      testsRun++;
      if (got !== exp)
      begin
         nFail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One classic cycle; held until ack is sampled, then released.
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDatI <= d;
      do @(posedge clk);
      while (wbAck !== 1'b1);
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   function logic [31:0] mk(logic st, logic [1:0] mp, logic [4:0] v, logic [2:0] w, logic m);
      return {20'h0_0000, m, w, v, mp, st};
   endfunction
   // Program one command, start it and poll until the unit is no longer busy.
   task run(input logic [31:0] cmd, input logic [15:0] len, input logic [63:0] str);
      logic [31:0] q;
      wb(1'b1, REG_CMD, cmd, q);
      wb(1'b1, REG_LEN, {16'h0000, len}, q);
      wb(1'b1, REG_START, 32'h0000_0000, q);
      wb(1'b1, REG_BASE_LO, B[31:0], q);
      wb(1'b1, REG_BASE_HI, B[63:32], q);
      wb(1'b1, REG_STRIDE_LO, str[31:0], q);
      wb(1'b1, REG_STRIDE_HI, str[63:32], q);
      nReq = 0;
      nRes = 0;
      wb(1'b1, REG_CTRL, 32'h0000_0001, q);
      do wb(1'b0, REG_CTRL, 32'h0000_0000, stat);
      while (stat[STAT_BUSY] !== 1'b0);
   endtask
   // ==========================================================
   // Scenarios.
   // ==========================================================
   task t_unit;
      logic [2:0] wc [4];
      wc = '{W8, W16, W32, W64};
      for (int s = 0; s < 4; s++)
      begin
         run(mk(1'b0, MOP_UNIT, VAR_PLAIN, wc[s], 1'b0), 16'h0002, 64'h0);
         chk("unit count", 64'd2, nReq);
         chk("unit addr", B + (64'h1 << s), aLog[1]);
         chk("unit data", ~(B + (64'h1 << s)), lastRes);
      end
   endtask
   task t_masked;
      maskPat <= 16'h000A;
      lat <= 4'h3;
      run(mk(1'b1, MOP_UNIT, VAR_PLAIN, W32, 1'b1), 16'h0004, 64'h0);
      chk("masked count", 64'd2, nReq);
      chk("masked addr", B + 64'd12, aLog[1]);
      chk("store flag", 64'd1, weSeen);
      lat <= 4'h0;
   endtask
   task t_maskop;
      maskPat <= 16'h0000;
      run(mk(1'b0, MOP_UNIT, VAR_MASK, W8, 1'b1), 16'h0009, 64'h0);
      chk("mask load count", 64'd2, nReq);
      chk("mask load addr", B + 64'd1, aLog[1]);
      chk("mask tail", 64'd1, taSeen);
      run(mk(1'b1, MOP_UNIT, VAR_MASK, W8, 1'b0), 16'h0011, 64'h0);
      chk("mask store count", 64'd3, nReq);
      run(mk(1'b0, MOP_UNIT, VAR_MASK, W16, 1'b0), 16'h0009, 64'h0);
      chk("mask wide count", 64'd0, nReq);
   endtask
   task t_stride;
      run(mk(1'b0, MOP_STRIDED, VAR_PLAIN, W64, 1'b0), 16'h0003, 64'hFFFF_FFFF_FFFF_FFF8);
      chk("neg stride", B - 64'd16, aLog[2]);
      run(mk(1'b0, MOP_STRIDED, VAR_PLAIN, W64, 1'b0), 16'h0003, 64'h0);
      chk("zero stride count", 64'd3, nReq);
      chk("zero stride addr", B, aLog[2]);
      repeat (2)
      begin
         run(mk(1'b0, MOP_STRIDED, VAR_PLAIN, W64, 1'b0) | 32'h0000_1000, 16'h0003, 64'h0);
         chk("zero reg counts", {nonIdem ? 32'd3 : 32'd1, 32'd3}, {nReq, nRes});
         nonIdem <= 1'b1;
      end
   endtask
   task t_index;
      elemIndex <= 64'hFFFF_FFFF_FFFF_FF03;
      run(mk(1'b0, 2'h1, VAR_PLAIN, W8, 1'b0), 16'h0001, 64'h0);
      chk("index narrow", B + 64'd3, aLog[0]);
      run(mk(1'b0, 2'h3, VAR_PLAIN, W64, 1'b0), 16'h0001, 64'h0);
      chk("index wide", B + 64'hFFFF_FFFF_FFFF_FF03, aLog[0]);
   endtask
   task t_ffirst;
      logic [31:0] q;
      faultOn <= 1'b1;
      faultAddr <= B + 64'd2;
      run(mk(1'b0, MOP_UNIT, VAR_FFIRST, W8, 1'b0), 16'h0004, 64'h0);
      wb(1'b0, REG_LEN, 32'h0000_0000, q);
      chk("trim len", 64'd2, q);
      chk("trim trap", 64'd0, stat[STAT_TRAP]);
      chk("trim flag", 64'd1, stat[STAT_TRIM]);
      chk("trim results", 64'd2, nRes);
      faultAddr <= B;
      run(mk(1'b0, MOP_UNIT, VAR_FFIRST, W8, 1'b0), 16'h0004, 64'h0);
      wb(1'b0, REG_LEN, 32'h0000_0000, q);
      chk("first len", 64'd4, q);
      chk("first trap", 64'd1, stat[STAT_TRAP]);
      faultOn <= 1'b0;
   endtask
   task t_illegal;
      logic [31:0] q;
      run(mk(1'b0, MOP_UNIT, VAR_MASK, W8, 1'b0) | 32'h0001_0000, 16'h0008, 64'h0);
      chk("illegal flag", 64'd1, stat[STAT_ILLEGAL]);
      chk("illegal count", 64'd0, nReq);
      wb(1'b0, 8'hFC, 32'h0000_0000, q);
      chk("unmapped read", 64'd0, q);
   endtask
   task summarize;
      $display("Checks run %0d, mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ==========================================================
   // Main sequence and watchdog.
   // ==========================================================
   initial
   begin
      {clk, nrst, wbCyc, wbStb, wbWe, faultOn, wbAdr, wbDatI, nonIdem} = '0;
      {wbSel, lat, maskPat, elemIndex, faultAddr} = {4'hF, 4'h0, 16'h0, 128'h0};
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_unit();
      t_masked();
      t_maskop();
      t_stride();
      t_index();
      t_ffirst();
      t_illegal();
      summarize();
   end
   // Whole run needs well under a thousand cycles; this cuts off a hang.
   initial
   begin
      #400000;
      nFail++;
      summarize();
   end
endmodule // vlsu_top_tb_top
